// file: design/desc_table_unit.sv
// descriptor table walker, gate decode and segment descriptor caches
`timescale 1ns/1ps
module desc_table_unit (
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    input  wire logic        CMD_VALID,
    input  wire logic [2:0]  CMD_OP,
    input  wire logic [1:0]  CMD_SEG,
    input  wire logic [15:0] CMD_SEL,
    input  wire logic [1:0]  CMD_CPL,
    input  wire logic [23:0] CMD_ADDR,
    input  wire logic        MEM_ACK,
    input  wire logic [15:0] MEM_RDATA,
    input  wire logic [1:0]  XLAT_SEG,
    input  wire logic [15:0] XLAT_OFFSET,
    output logic             BUSY,
    output logic             DONE,
    output logic             EXC_VALID,
    output logic [7:0]       EXC_VECTOR,
    output logic             MEM_REQ,
    output logic             MEM_LOCK,
    output logic [23:0]      MEM_ADDR,
    output logic [2:0]       GATE_KIND,
    output logic [15:0]      GATE_DEST_SEL,
    output logic [15:0]      GATE_DEST_OFS,
    output logic [1:0]       TARGET_PRIV,
    output logic             COPY_EN,
    output logic [4:0]       COPY_WORDS,
    output logic             IF_CLEAR,
    output logic [23:0]      PHYS_ADDR,
    output logic             XLAT_FAULT
);
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_CHECK} st_e;

    typedef struct packed {
        st_e                 st;
        dt_pkg::op_e         op;
        logic [1:0]          seg;
        logic [1:0]          cpl;
        logic                dest_phase;
        logic [1:0]          widx;
        logic [15:0]         w0, w1, w2;
        logic [23:0]         gbl_base;
        logic [15:0]         gbl_limit;
        logic [23:0]         loc_base;
        logic [15:0]         loc_limit;
        dt_pkg::cache_entry_s [dt_pkg::NUM_SEGS-1:0] cache;
        logic [2:0]          gtype;
        logic [4:0]          gwc;
        logic [15:0]         gofs;
        logic                busy, done, exc_valid, if_clear;
        logic [7:0]          exc_vec;
        logic                mem_req, mem_lock;
        logic [23:0]         mem_addr;
        logic [2:0]          kind;
        logic [15:0]         dsel, dofs;
        logic [1:0]          tpriv;
        logic                copy_en;
        logic [4:0]          copy_words;
        logic [23:0]         phys;
        logic                xfault;
    } state_s;

    state_s        s_reg, s_next;
    desc_fields_if dif ();

    desc_decode u_dec (
        .d (dif.dec)
    );

    assign dif.word0 = s_reg.w0;
    assign dif.word1 = s_reg.w1;
    assign dif.word2 = s_reg.w2;

    // entry address and limit test; MSB flags out of limit
    function automatic logic [24:0] locate(input logic [15:0] sel,
                                           input state_s s);
        logic [23:0] base;
        logic [15:0] limit;
        logic [15:0] last;
        base  = sel[dt_pkg::SEL_TABLE_BIT] ? s.loc_base : s.gbl_base;
        limit = sel[dt_pkg::SEL_TABLE_BIT] ? s.loc_limit : s.gbl_limit;
        last  = {sel[dt_pkg::SEL_IDX_HI:dt_pkg::SEL_IDX_LO],
                 dt_pkg::DESC_LAST_BYTE};
        return {last > limit,
                base + {dt_pkg::ADDR_PAD,
                        sel[dt_pkg::SEL_IDX_HI:dt_pkg::SEL_IDX_LO],
                        dt_pkg::DESC_FIRST_BYTE}};
    endfunction

    always_comb begin
        logic [24:0] loc;
        logic [7:0]  ev;
        logic        start;
        logic        lock;
        logic [23:0] addr;
        logic        ok;
        loc   = '0;
        ev    = dt_pkg::EXC_NONE;
        start = 1'b0;
        lock  = 1'b1;
        addr  = '0;
        ok    = 1'b0;
        s_next = s_reg;
        s_next.done      = 1'b0;
        s_next.exc_valid = 1'b0;
        s_next.if_clear  = 1'b0;
        // translation serves from the cached base only
        s_next.phys   = s_reg.cache[XLAT_SEG].base
                        + {dt_pkg::ADDR_PAD, XLAT_OFFSET};
        s_next.xfault = XLAT_OFFSET > s_reg.cache[XLAT_SEG].limit;
        case (s_reg.st)
            ST_IDLE: begin
                if (CMD_VALID) begin
                    s_next.op         = dt_pkg::op_e'(CMD_OP);
                    s_next.seg        = CMD_SEG;
                    s_next.cpl        = CMD_CPL;
                    s_next.dest_phase = 1'b0;
                    loc = locate(CMD_SEL, s_reg);
                    addr = loc[23:0];
                    case (dt_pkg::op_e'(CMD_OP))
                        dt_pkg::OP_LOAD_GLOBAL: begin
                            if (CMD_CPL != dt_pkg::PRIV_TOP)
                                ev = dt_pkg::EXC_GENERAL;
                            // operand is plain memory, not a descriptor
                            addr = CMD_ADDR;
                            lock = 1'b0;
                        end
                        dt_pkg::OP_LOAD_LOCAL: begin
                            if (CMD_CPL != dt_pkg::PRIV_TOP
                                || CMD_SEL[dt_pkg::SEL_TABLE_BIT]
                                || loc[24])
                                ev = dt_pkg::EXC_GENERAL;
                        end
                        dt_pkg::OP_VECTOR_GATE: begin
                            // gate address comes from the vector table logic
                            addr = CMD_ADDR;
                        end
                        default: begin
                            if (loc[24])
                                ev = dt_pkg::EXC_GENERAL;
                        end
                    endcase
                    start = (ev == dt_pkg::EXC_NONE);
                end
            end
            ST_FETCH: begin
                if (MEM_ACK) begin
                    case (s_reg.widx)
                        2'h0:    s_next.w0 = MEM_RDATA;
                        2'h1:    s_next.w1 = MEM_RDATA;
                        default: s_next.w2 = MEM_RDATA;
                    endcase
                    s_next.widx = s_reg.widx + 2'h1;
                    s_next.mem_addr = s_reg.mem_addr + dt_pkg::WORD_STEP;
                    if (s_reg.widx == dt_pkg::LAST_WORD) begin
                        s_next.st       = ST_CHECK;
                        s_next.mem_req  = 1'b0;
                        s_next.mem_lock = 1'b0;
                    end
                end
            end
            default: begin
                case (s_reg.op)
                    dt_pkg::OP_LOAD_GLOBAL: begin
                        s_next.gbl_limit = dif.limit;
                        s_next.gbl_base  = dif.base;
                    end
                    dt_pkg::OP_LOAD_LOCAL: begin
                        // must be a system local table entry
                        if (dif.is_seg
                            || dif.sys_type != dt_pkg::TYPE_LOCAL_TABLE)
                            ev = dt_pkg::EXC_GENERAL;
                        else if (!dif.present)
                            ev = dt_pkg::EXC_NOT_PRESENT;
                        else begin
                            s_next.loc_base  = dif.base;
                            s_next.loc_limit = dif.limit;
                        end
                    end
                    dt_pkg::OP_LOAD_SEG: begin
                        if (!dif.is_seg)
                            ev = dt_pkg::EXC_GENERAL;
                        else if (!dif.present)
                            ev = dt_pkg::EXC_NOT_PRESENT;
                        else begin
                            s_next.cache[s_reg.seg] = {dif.base, dif.limit,
                                                       dif.access};
                        end
                    end
                    default: begin
                        if (!s_reg.dest_phase) begin
                            if (dif.is_seg
                                || !dif.sys_type[dt_pkg::GATE_TYPE_BIT])
                                ev = dt_pkg::EXC_GENERAL;
                            else if (s_reg.op == dt_pkg::OP_GATE
                                && (dif.sys_type == dt_pkg::TYPE_INT_GATE
                                || dif.sys_type == dt_pkg::TYPE_TRAP_GATE))
                                ev = dt_pkg::EXC_GENERAL;
                            else if (s_reg.op == dt_pkg::OP_VECTOR_GATE
                                && dif.sys_type == dt_pkg::TYPE_CALL_GATE)
                                ev = dt_pkg::EXC_GENERAL;
                            else if (!dif.present)
                                ev = dt_pkg::EXC_NOT_PRESENT;
                            else begin
                                loc = locate(dif.dest_sel, s_reg);
                                if (loc[24])
                                    ev = dt_pkg::EXC_GENERAL;
                                else begin
                                    s_next.gtype      = dif.sys_type;
                                    s_next.gwc        = dif.wcount;
                                    s_next.gofs       = dif.dest_ofs;
                                    s_next.dsel       = dif.dest_sel;
                                    s_next.dest_phase = 1'b1;
                                    addr  = loc[23:0];
                                    start = 1'b1;
                                end
                            end
                        end else begin
                            if (s_reg.gtype == dt_pkg::TYPE_TASK_GATE)
                                ok = !dif.is_seg && (dif.sys_type
                                    == dt_pkg::TYPE_TASK_STATE_AVAIL
                                    || dif.sys_type
                                    == dt_pkg::TYPE_TASK_STATE_BUSY);
                            else
                                ok = dif.is_code;
                            if (!ok)
                                ev = dt_pkg::EXC_GENERAL;
                            else if (!dif.present)
                                ev = dt_pkg::EXC_NOT_PRESENT;
                            else begin
                                s_next.kind  = s_reg.gtype;
                                // target privilege for task state, code
                                s_next.tpriv = dif.priv;
                                // task switch follows; no entry offset
                                s_next.dofs = (s_reg.gtype
                                    == dt_pkg::TYPE_TASK_GATE)
                                    ? dt_pkg::OFS_NONE : s_reg.gofs;
                                s_next.copy_en = (s_reg.gtype
                                    == dt_pkg::TYPE_CALL_GATE)
                                    && (dif.priv < s_reg.cpl);
                                s_next.copy_words = s_next.copy_en
                                    ? s_reg.gwc : dt_pkg::WCOUNT_NONE;
                                s_next.if_clear = (s_reg.gtype
                                    == dt_pkg::TYPE_INT_GATE);
                            end
                        end
                    end
                endcase
                if (!start) begin
                    s_next.st   = ST_IDLE;
                    s_next.busy = 1'b0;
                    s_next.done = (ev == dt_pkg::EXC_NONE);
                end
            end
        endcase
        if (ev != dt_pkg::EXC_NONE) begin
            s_next.exc_valid = 1'b1;
            s_next.exc_vec   = ev;
            s_next.st        = ST_IDLE;
            s_next.busy      = 1'b0;
        end
        if (start) begin
            s_next.st       = ST_FETCH;
            s_next.busy     = 1'b1;
            s_next.widx     = dt_pkg::FIRST_WORD;
            s_next.mem_req  = 1'b1;
            s_next.mem_lock = lock;
            s_next.mem_addr = addr;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign BUSY          = s_reg.busy;
    assign DONE          = s_reg.done;
    assign EXC_VALID     = s_reg.exc_valid;
    assign EXC_VECTOR    = s_reg.exc_vec;
    assign MEM_REQ       = s_reg.mem_req;
    assign MEM_LOCK      = s_reg.mem_lock;
    assign MEM_ADDR      = s_reg.mem_addr;
    assign GATE_KIND     = s_reg.kind;
    assign GATE_DEST_SEL = s_reg.dsel;
    assign GATE_DEST_OFS = s_reg.dofs;
    assign TARGET_PRIV   = s_reg.tpriv;
    assign COPY_EN       = s_reg.copy_en;
    assign COPY_WORDS    = s_reg.copy_words;
    assign IF_CLEAR      = s_reg.if_clear;
    assign PHYS_ADDR     = s_reg.phys;
    assign XLAT_FAULT    = s_reg.xfault;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    AST_LOCKED_FETCH: assert property (
        MEM_REQ && s_reg.op != dt_pkg::OP_LOAD_GLOBAL |-> MEM_LOCK)
        else $error("descriptor fetch without bus lock");
    AST_IF_CLEAR_INT: assert property (
        IF_CLEAR |-> DONE && GATE_KIND == dt_pkg::TYPE_INT_GATE)
        else $error("interrupt flag cleared by wrong gate");
    AST_COPY_CALL: assert property (
        COPY_EN |-> GATE_KIND == dt_pkg::TYPE_CALL_GATE)
        else $error("word copy from non-call gate");
    AST_TASK_NO_OFS: assert property (
        DONE && GATE_KIND == dt_pkg::TYPE_TASK_GATE
        && s_reg.op != dt_pkg::OP_LOAD_SEG |-> GATE_DEST_OFS == 16'h0000)
        else $error("task gate produced an entry offset");
    AST_EXC_CODE: assert property (
        EXC_VALID |-> EXC_VECTOR == 8'h0B || EXC_VECTOR == 8'h0D)
        else $error("unknown exception vector");
    AST_PRIV_LOAD: assert property (
        s_reg.st == ST_IDLE && CMD_VALID && CMD_CPL != 2'h0
        && CMD_OP == 3'h1 |=> EXC_VALID && EXC_VECTOR == 8'h0D && !BUSY)
        else $error("unprivileged table load not refused");
    AST_LIMIT_FAULT: assert property (
        s_reg.st == ST_IDLE && CMD_VALID && CMD_OP == 3'h0
        && {CMD_SEL[15:3], 3'h7} > (CMD_SEL[2] ? s_reg.loc_limit
                                    : s_reg.gbl_limit)
        |=> EXC_VALID && EXC_VECTOR == 8'h0D && !MEM_REQ)
        else $error("out of limit selector not faulted");
    AST_CACHE_HOLD: assert property (
        !(s_reg.st == ST_CHECK && s_reg.op == dt_pkg::OP_LOAD_SEG)
        |=> $stable(s_reg.cache))
        else $error("descriptor cache changed outside a load");
    AST_XLAT_SUM: assert property (
        1'b1 |=> PHYS_ADDR == $past(s_reg.cache[XLAT_SEG].base)
                 + {dt_pkg::ADDR_PAD, $past(XLAT_OFFSET)})
        else $error("translated address is not base plus offset");

    COV_SEG_LOAD: cover property (
        s_reg.st == ST_CHECK && s_reg.op == dt_pkg::OP_LOAD_SEG ##1 DONE);
    COV_INT_GATE: cover property (IF_CLEAR);
    COV_CALL_COPY: cover property (COPY_EN);
    COV_NOT_PRESENT: cover property (EXC_VALID && EXC_VECTOR == 8'h0B);
endmodule

// file: design/dt_pkg.sv
// constants and types for descriptor table and gate decode
package dt_pkg;
    typedef enum logic [2:0] {
        OP_LOAD_SEG,
        OP_LOAD_GLOBAL,
        OP_LOAD_LOCAL,
        OP_GATE,
        OP_VECTOR_GATE
    } op_e;

    localparam logic [2:0] TYPE_TASK_STATE_AVAIL = 3'h1;
    localparam logic [2:0] TYPE_LOCAL_TABLE      = 3'h2;
    localparam logic [2:0] TYPE_TASK_STATE_BUSY  = 3'h3;
    localparam logic [2:0] TYPE_CALL_GATE        = 3'h4;
    localparam logic [2:0] TYPE_TASK_GATE        = 3'h5;
    localparam logic [2:0] TYPE_INT_GATE         = 3'h6;
    localparam logic [2:0] TYPE_TRAP_GATE        = 3'h7;

    // access byte and word field positions
    localparam int ACC_BYTE_HI  = 15;
    localparam int ACC_BYTE_LO  = 8;
    localparam int ACC_PRESENT  = 7;
    localparam int ACC_PRIV_HI  = 6;
    localparam int ACC_PRIV_LO  = 5;
    localparam int ACC_SEG      = 4;
    localparam int ACC_EXEC     = 3;
    localparam int ACC_TYPE_HI  = 2;
    localparam int ACC_TYPE_LO  = 0;
    localparam int GATE_TYPE_BIT = 2;
    localparam int BASE_HI_MSB  = 7;
    localparam int WCOUNT_HI    = 4;

    // selector fields
    localparam int SEL_RPL_HI    = 1;
    localparam int SEL_TABLE_BIT = 2;
    localparam int SEL_IDX_HI    = 15;
    localparam int SEL_IDX_LO    = 3;

    localparam logic [2:0]  DESC_FIRST_BYTE = 3'h0;
    localparam logic [2:0]  DESC_LAST_BYTE  = 3'h7;
    localparam logic [1:0]  LAST_WORD       = 2'h2;
    localparam logic [1:0]  FIRST_WORD      = 2'h0;
    localparam logic [23:0] WORD_STEP       = 24'h000002;
    localparam logic [7:0]  ADDR_PAD        = 8'h00;
    localparam logic [15:0] OFS_NONE        = 16'h0000;
    localparam logic [4:0]  WCOUNT_NONE     = 5'h00;
    localparam logic [1:0]  PRIV_TOP        = 2'h0;

    localparam logic [7:0] EXC_NONE        = 8'h00;
    localparam logic [7:0] EXC_NOT_PRESENT = 8'h0B;
    localparam logic [7:0] EXC_GENERAL     = 8'h0D;

    localparam int NUM_SEGS = 4;

    typedef struct packed {
        logic [23:0] base;
        logic [15:0] limit;
        logic [7:0]  access;
    } cache_entry_s;
endpackage

// file: design/desc_fields_if.sv
// descriptor words and their decoded fields
`timescale 1ns/1ps
interface desc_fields_if;
    logic [15:0] word0, word1, word2;
    logic [7:0]  access;
    logic        present, is_seg, is_code;
    logic [1:0]  priv;
    logic [2:0]  sys_type;
    logic [23:0] base;
    logic [15:0] limit, dest_sel, dest_ofs;
    logic [4:0]  wcount;
    modport src (output word0, word1, word2,
                 input access, present, is_seg, is_code, priv,
                 input sys_type, base, limit, dest_sel, dest_ofs, wcount);
    modport dec (input word0, word1, word2,
                 output access, present, is_seg, is_code, priv,
                 output sys_type, base, limit, dest_sel, dest_ofs, wcount);
endinterface

// file: design/desc_decode.sv
// field decoder for segment, system and gate descriptors
`timescale 1ns/1ps
module desc_decode (
    desc_fields_if.dec d
);
    assign d.access   = d.word2[dt_pkg::ACC_BYTE_HI:dt_pkg::ACC_BYTE_LO];
    assign d.present  = d.access[dt_pkg::ACC_PRESENT];
    assign d.priv     = d.access[dt_pkg::ACC_PRIV_HI:dt_pkg::ACC_PRIV_LO];
    assign d.is_seg   = d.access[dt_pkg::ACC_SEG];
    assign d.is_code  = d.access[dt_pkg::ACC_SEG] & d.access[dt_pkg::ACC_EXEC];
    assign d.sys_type = d.access[dt_pkg::ACC_TYPE_HI:dt_pkg::ACC_TYPE_LO];
    assign d.base     = {d.word2[dt_pkg::BASE_HI_MSB:0], d.word1};
    assign d.limit    = d.word0;
    // gate layout reuses the same words
    assign d.wcount   = d.word2[dt_pkg::WCOUNT_HI:0];
    assign d.dest_sel = d.word1;
    assign d.dest_ofs = d.word0;
endmodule

// file: test/desc_mem.sv
// descriptor memory model answering word reads
`timescale 1ns/1ps
module desc_mem (
    input  wire logic        REF_CLK,
    input  wire logic        MEM_REQ,
    input  wire logic        MEM_LOCK,
    input  wire logic [23:0] MEM_ADDR,
    output logic             MEM_ACK,
    output logic [15:0]      MEM_RDATA
);
    logic [15:0] mem [logic [23:0]];
    logic        slow = 1'b0;
    logic        last_lock = 1'b0;
    logic [23:0] last_addr = 24'h000000;
    int          wait_cnt = 0;
    initial MEM_ACK = 1'b0;
    initial MEM_RDATA = 16'h0000;
    always @(posedge REF_CLK) begin
        #1;
        if (MEM_REQ && wait_cnt == 0) begin
            {MEM_ACK, MEM_RDATA} = {1'b1, mem[MEM_ADDR]};
            {last_addr, last_lock} = {MEM_ADDR, MEM_LOCK};
            wait_cnt = slow ? 2 : 0;
        end else begin
            // read word inverted every cycle once the answer is gone
            {MEM_ACK, MEM_RDATA} = {1'b0, ~MEM_RDATA};
            if (MEM_REQ) wait_cnt = wait_cnt - 1;
        end
    end
endmodule

// file: test/tb.sv
// random and corner-case bench for the descriptor table unit
`timescale 1ns/1ps
module tb;
    logic        REF_CLK, RESETN, CMD_VALID, MEM_ACK, BUSY, DONE;
    logic        EXC_VALID, MEM_REQ, MEM_LOCK, COPY_EN, IF_CLEAR;
    logic        XLAT_FAULT, if_seen;
    logic [1:0]  CMD_SEG, CMD_CPL, XLAT_SEG, TARGET_PRIV;
    logic [2:0]  CMD_OP, GATE_KIND;
    logic [4:0]  COPY_WORDS;
    logic [7:0]  EXC_VECTOR;
    logic [15:0] CMD_SEL, MEM_RDATA, XLAT_OFFSET, GATE_DEST_SEL;
    logic [15:0] GATE_DEST_OFS, rnd, lim, ofs;
    logic [23:0] CMD_ADDR, MEM_ADDR, PHYS_ADDR, base;
    int          err_count = 0;
    int          compares = 0;
    desc_table_unit u_dut (
        .REF_CLK      (REF_CLK),      .RESETN       (RESETN),
        .CMD_VALID    (CMD_VALID),    .CMD_OP       (CMD_OP),
        .CMD_SEG      (CMD_SEG),      .CMD_SEL      (CMD_SEL),
        .CMD_CPL      (CMD_CPL),      .CMD_ADDR     (CMD_ADDR),
        .MEM_ACK      (MEM_ACK),      .MEM_RDATA    (MEM_RDATA),
        .XLAT_SEG     (XLAT_SEG),     .XLAT_OFFSET  (XLAT_OFFSET),
        .BUSY         (BUSY),         .DONE         (DONE),
        .EXC_VALID    (EXC_VALID),    .EXC_VECTOR   (EXC_VECTOR),
        .MEM_REQ      (MEM_REQ),      .MEM_LOCK     (MEM_LOCK),
        .MEM_ADDR     (MEM_ADDR),     .GATE_KIND    (GATE_KIND),
        .GATE_DEST_SEL(GATE_DEST_SEL), .GATE_DEST_OFS(GATE_DEST_OFS),
        .TARGET_PRIV  (TARGET_PRIV),  .COPY_EN      (COPY_EN),
        .COPY_WORDS   (COPY_WORDS),   .IF_CLEAR     (IF_CLEAR),
        .PHYS_ADDR    (PHYS_ADDR),    .XLAT_FAULT   (XLAT_FAULT)
    );
    desc_mem u_mem (
        .REF_CLK  (REF_CLK),  .MEM_REQ  (MEM_REQ),  .MEM_LOCK (MEM_LOCK),
        .MEM_ADDR (MEM_ADDR), .MEM_ACK  (MEM_ACK),  .MEM_RDATA(MEM_RDATA)
    );
    function automatic logic [15:0] nx(input logic [15:0] x);
        x = x ^ (x << 7);
        x = x ^ (x >> 9);
        return x ^ (x << 8);
    endfunction
    // physical address wraps at 24 bits
    function automatic logic [23:0] exp_phys(input logic [23:0] b,
                                             input logic [15:0] o);
        return b + {8'h00, o};
    endfunction
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [23:0] a, input logic [15:0] w0, w1, w2);
        u_mem.mem[a] = w0;
        u_mem.mem[a + 24'h000002] = w1;
        u_mem.mem[a + 24'h000004] = w2;
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic run(input logic [2:0] op, input logic [15:0] sel,
                       input logic [1:0] cpl, input logic [7:0] exv);
        int          n;
        logic [9:0]  got;
        n = 0;
        rnd = nx(rnd);
        u_mem.slow = rnd[0];
        {CMD_OP, CMD_SEL, CMD_CPL, CMD_VALID} = {op, sel, cpl, 1'b1};
        @(posedge REF_CLK);
        #1 CMD_VALID = 1'b0;
        while (DONE !== 1'b1 && EXC_VALID !== 1'b1 && n < 200) begin
            @(posedge REF_CLK);
            #1 n++;
        end
        if_seen = IF_CLEAR;
        if (n >= 200) begin
            check(1'b1, 1'b0);
            give_verdict();
        end
        got = {BUSY, DONE, EXC_VALID ? EXC_VECTOR : 8'h00};
        check(got, {1'b0, exv == 8'h00, exv});
        $display("test op %0h sel %h ended at %0t", op, sel, $time);
        // answer pulse passes before the next request is raised
        @(posedge REF_CLK);
        #1;
    endtask
    initial begin
        rnd = 16'hE505;
        {RESETN, CMD_VALID, CMD_OP, CMD_SEG, CMD_SEL, CMD_CPL} = '0;
        {CMD_ADDR, XLAT_SEG, XLAT_OFFSET} = '0;
        repeat (6) @(posedge REF_CLK);
        #1 RESETN = 1'b1;
        put(24'h000100, 16'h00FF, 16'h1000, 16'h0000);
        CMD_ADDR = 24'h000100;
        run(3'h1, 16'h0000, 2'h1, 8'h0D);
        run(3'h1, 16'h0000, 2'h0, 8'h00);
        check(u_mem.last_lock, 1'b0);
        rnd = nx(rnd);
        base = {rnd[7:0], rnd ^ 16'h5A5A};
        lim = nx(rnd) | 16'h0100;
        put(24'h001010, lim, base[15:0], {8'h92, base[23:16]});
        CMD_SEG = 2'h2;
        run(3'h0, 16'h0013, 2'h3, 8'h00);
        check(u_mem.last_addr, 24'h001014);
        check(u_mem.last_lock, 1'b1);
        XLAT_SEG = 2'h2;
        for (int i = 0; i < 6; i++) begin
            rnd = nx(rnd);
            ofs = (i < 2) ? lim + i[15:0] : rnd;
            XLAT_OFFSET = ofs;
            @(posedge REF_CLK);
            #1 check(PHYS_ADDR, exp_phys(base, ofs));
            check(XLAT_FAULT, ofs > lim);
        end
        put(24'h0010F8, 16'h0FFF, 16'h0000, 16'h9200);
        CMD_SEG = 2'h1;
        run(3'h0, 16'h00F8, 2'h0, 8'h00);
        run(3'h0, 16'h0100, 2'h0, 8'h0D);
        {XLAT_SEG, XLAT_OFFSET} = {2'h1, 16'h0FFF};
        @(posedge REF_CLK);
        #1 check({XLAT_FAULT, PHYS_ADDR}, 25'h0000FFF);
        // run draws a new random word, so the gate offset is kept apart
        rnd = nx(rnd);
        ofs = rnd;
        put(24'h001018, ofs, 16'h0020, {11'h420, ofs[4:0]});
        put(24'h001020, 16'hFFFF, 16'h0000, 16'h9A00);
        run(3'h3, 16'h0018, 2'h3, 8'h00);
        check({GATE_KIND, GATE_DEST_SEL, GATE_DEST_OFS},
              {19'h40020, ofs});
        check({COPY_EN, COPY_WORDS}, {1'b1, ofs[4:0]});
        put(24'h001028, 16'hFFFF, 16'h0000, 16'h9200);
        put(24'h001030, rnd, 16'h0028, 16'h8400);
        run(3'h3, 16'h0030, 2'h0, 8'h0D);
        put(24'h001038, rnd, 16'h0020, 16'h0400);
        run(3'h3, 16'h0038, 2'h0, 8'h0B);
        put(24'h001040, rnd, 16'h0020, 16'h8600);
        run(3'h3, 16'h0040, 2'h0, 8'h0D);
        // local table entry with privilege 3, which the load ignores
        put(24'h001050, 16'h0007, 16'h3000, 16'hE200);
        put(24'h003000, 16'h0ABC, 16'h4000, 16'h9200);
        run(3'h2, 16'h0050, 2'h2, 8'h0D);
        run(3'h2, 16'h0050, 2'h0, 8'h00);
        CMD_SEG = 2'h3;
        run(3'h0, 16'h0004, 2'h0, 8'h00);
        check(u_mem.last_addr, 24'h003004);
        run(3'h0, 16'h000C, 2'h0, 8'h0D);
        put(24'h001048, 16'hFFFF, 16'h0000, 16'hC100);
        CMD_ADDR = 24'h002000;
        for (int t = 5; t < 8; t++) begin
            rnd = nx(rnd);
            ofs = rnd;
            put(24'h002000, ofs, (t == 5) ? 16'h0048 : 16'h0020,
                {5'h10, t[2:0], 3'h0, ofs[4:0]});
            run(3'h4, 16'h0000, 2'h0, 8'h00);
            check({GATE_KIND, if_seen, COPY_EN, COPY_WORDS},
                  {t[2:0], t == 6, 6'h00});
            check({TARGET_PRIV, GATE_DEST_OFS},
                  {(t == 5) ? 18'h20000 : {2'h0, ofs}});
        end
        give_verdict();
    end
endmodule
